// [aks_map.svh]
// Register offsets, field codes, reset values and fixed counts
`ifndef AKS_MAP_SVH
`define AKS_MAP_SVH
`define AKS_ADR_LK_EN   8'h00
`define AKS_ADR_KSEL0   8'h04
`define AKS_ADR_KSEL1   8'h08
`define AKS_ADR_ROFF    8'h0c
`define AKS_ADR_STAT    8'h10
`define AKS_ADR_RTYPE   3'b010
`define AKS_ADR_RLIM    3'b011
`define AKS_RST_LK_EN   32'h0000_0000
`define AKS_RST_KSEL    32'h0000_0000
`define AKS_RST_ROFF    8'h00
`define AKS_RST_RTYPE   3'h0
`define AKS_RST_RLIM    16'h0000
`define AKS_ET_IP6      16'h86dd
`define AKS_ET_IP4      16'h0800
`define AKS_ET_ARP      16'h0806
`define AKS_ET_RARP     16'h8035
`define AKS_NIB_IP6     4'h6
`define AKS_NIB_IP4     4'h4
`define AKS_RAW_WIDE    57
`define AKS_RAW_NARROW  24
`define AKS_POS_PLUS20  9'h014
`define AKS_POS_PLUS40  9'h028
`define AKS_RNG_N       8
`define AKS_RT_DPORT    3'h0
`define AKS_RT_SPORT    3'h1
`define AKS_RT_EITHER   3'h2
`define AKS_RT_VID      3'h3
`define AKS_RT_DSCP     3'h4
`define AKS_RT_FIELD    3'h5
`endif

// [aks_pkg.sv]
// Types shared by the key select and range check block
package aks_pkg;
    typedef enum logic [3:0] {
        AKS_KEY_MAC, AKS_KEY_ARP, AKS_KEY_IP4_VLAN, AKS_KEY_IP6_VLAN,
        AKS_KEY_SEVEN, AKS_KEY_IP4_L4, AKS_KEY_IP4_GEN, AKS_KEY_CUSTOM,
        AKS_KEY_NONE
    } aks_key_t;
    typedef enum logic [2:0] {
        AKS_CLS_IP6_MC, AKS_CLS_IP6_UC, AKS_CLS_IP4_MC, AKS_CLS_IP4_UC,
        AKS_CLS_ARP, AKS_CLS_MAC, AKS_CLS_NONE
    } aks_cls_t;
    typedef struct packed {
        logic        valid;
        logic [3:0]  port;
        logic        control_word_frame;
        logic [15:0] type_len;
        logic [3:0]  ip_ver;
        logic        ip_mcast;
        logic        l4_tcp_udp;
        logic [15:0] sport;
        logic [15:0] dport;
        logic [11:0] vid;
        logic [5:0]  dscp;
        logic [7:0]  l3_pos;
        logic [7:0]  tl_pos;
        logic        raw_key_enable;
        logic [1:0]  raw_key_position;
    } aks_frame_t;
    typedef struct packed {
        logic        valid;
        logic [3:0]  port;
        aks_key_t    key0;
        aks_key_t    key1;
        logic        l2_null;
        logic [7:0]  range_flag_vector0;
        logic [7:0]  range_flag_vector1;
    } aks_res_t;
    typedef struct packed {
        logic       valid;
        logic [3:0] port;
        logic [1:0] hit;
    } aks_hit_t;
endpackage

// [aks_key_select.sv]
// Key selection, raw keys and range checkers for the ACL match table
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "aks_map.svh"
module aks_key_select
    import aks_pkg::*;
#(
    parameter int NP = 8,   // Number of ports, at most 10
    parameter int FB = 128  // Frame bytes visible to extraction
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    input  wire aks_frame_t    frame_i,
    input  wire logic [FB*8-1:0] frame_bytes_i,
    input  wire aks_hit_t      hit_i,
    output aks_res_t           res_o,
    output logic [`AKS_RAW_WIDE*8-1:0]   raw_wide_o,
    output logic [`AKS_RAW_NARROW*8-1:0] raw_narrow_o,
    output logic [1:0]         hit_used_o
);

    // Configuration state
    logic [2*NP-1:0] lk_en_q;      // Lookup enable, bit 2*port+lookup
    logic [3*NP-1:0] ksel0_q;      // Key choice, lookup 0
    logic [3*NP-1:0] ksel1_q;      // Key choice, lookup 1
    logic [7:0]      roff_q;       // Shared selected-field offset
    logic [2:0]      rtype_q [`AKS_RNG_N];
    logic [15:0]     rlo_q   [`AKS_RNG_N];
    logic [15:0]     rhi_q   [`AKS_RNG_N];
    logic [15:0]     fcnt_q;       // Frames seen, for status
    logic            ack_q;
    logic [31:0]     rdat_q;

    // Bus strobes
    logic            acc;
    logic            wr;
    logic [2:0]      ridx;
    assign acc  = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr   = acc & wb_we_i;
    assign ridx = wb_adr_i[4:2];

    // Write words merged into the old contents, sliced where stored
    logic [31:0] m_lk, m_k0, m_k1, m_lo, m_hi;
    assign m_lk = merge(32'(lk_en_q), wb_dat_i, wb_sel_i);
    assign m_k0 = merge(32'(ksel0_q), wb_dat_i, wb_sel_i);
    assign m_k1 = merge(32'(ksel1_q), wb_dat_i, wb_sel_i);
    assign m_lo = merge({16'h0000, rlo_q[ridx]}, wb_dat_i, wb_sel_i);
    assign m_hi = merge({rhi_q[ridx], 16'h0000}, wb_dat_i, wb_sel_i);

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Wishbone ack: one cycle, dropped the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end

    // Per-port enables and key choices
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lk_en_q <= (2*NP)'(`AKS_RST_LK_EN);
            ksel0_q <= (3*NP)'(`AKS_RST_KSEL);
            ksel1_q <= (3*NP)'(`AKS_RST_KSEL);
        end else if (wr) begin
            // Widths above the port fields are discarded
            case (wb_adr_i)
                `AKS_ADR_LK_EN: begin
                    lk_en_q <= m_lk[2*NP-1:0];
                end
                `AKS_ADR_KSEL0: begin
                    ksel0_q <= m_k0[3*NP-1:0];
                end
                `AKS_ADR_KSEL1: begin
                    ksel1_q <= m_k1[3*NP-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Shared field offset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            roff_q <= `AKS_RST_ROFF;
        end else if (wr && wb_adr_i == `AKS_ADR_ROFF && wb_sel_i[0]) begin
            roff_q <= wb_dat_i[7:0];
        end
    end

    // Range checker type and limits, one word each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `AKS_RNG_N; i++) begin
                rtype_q[i] <= `AKS_RST_RTYPE;
                rlo_q[i]   <= `AKS_RST_RLIM;
                rhi_q[i]   <= `AKS_RST_RLIM;
            end
        end else if (wr) begin
            if (wb_adr_i[7:5] == `AKS_ADR_RTYPE && wb_sel_i[0]) begin
                rtype_q[ridx] <= wb_dat_i[2:0];
            end
            if (wb_adr_i[7:5] == `AKS_ADR_RLIM) begin
                // Start in the low half, end in the high half
                rlo_q[ridx] <= m_lo[15:0];
                rhi_q[ridx] <= m_hi[31:16];
            end
        end
    end

    // Read mux; unmapped offsets read as zero and still ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (acc) begin
            rdat_q <= 32'h0000_0000;
            if (wb_adr_i[7:5] == `AKS_ADR_RTYPE) begin
                rdat_q <= {29'h0000_0000, rtype_q[ridx]};
            end else if (wb_adr_i[7:5] == `AKS_ADR_RLIM) begin
                rdat_q <= {rhi_q[ridx], rlo_q[ridx]};
            end else begin
                case (wb_adr_i)
                    `AKS_ADR_LK_EN: rdat_q <= 32'(lk_en_q);
                    `AKS_ADR_KSEL0: rdat_q <= 32'(ksel0_q);
                    `AKS_ADR_KSEL1: rdat_q <= 32'(ksel1_q);
                    `AKS_ADR_ROFF:  rdat_q <= {24'h00_0000, roff_q};
                    `AKS_ADR_STAT:  rdat_q <= {res_o.key1, res_o.key0,
                                               8'h00, fcnt_q};
                    default:        rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Frame classification
    aks_cls_t cls;
    logic     is_ip;
    always_comb begin
        cls = AKS_CLS_MAC;
        if (frame_i.control_word_frame) begin
            // Nibble after the label stack decides
            if (frame_i.ip_ver == `AKS_NIB_IP6) begin
                cls = frame_i.ip_mcast ? AKS_CLS_IP6_MC
                                       : AKS_CLS_IP6_UC;
            end else if (frame_i.ip_ver == `AKS_NIB_IP4) begin
                cls = frame_i.ip_mcast ? AKS_CLS_IP4_MC
                                       : AKS_CLS_IP4_UC;
            end else begin
                cls = AKS_CLS_NONE;
            end
        end else if (frame_i.type_len == `AKS_ET_IP6 &&
                     frame_i.ip_ver == `AKS_NIB_IP6) begin
            cls = frame_i.ip_mcast ? AKS_CLS_IP6_MC
                                   : AKS_CLS_IP6_UC;
        end else if (frame_i.type_len == `AKS_ET_IP4 &&
                     frame_i.ip_ver == `AKS_NIB_IP4) begin
            cls = frame_i.ip_mcast ? AKS_CLS_IP4_MC
                                   : AKS_CLS_IP4_UC;
        end else if (frame_i.type_len == `AKS_ET_ARP ||
                     frame_i.type_len == `AKS_ET_RARP) begin
            cls = AKS_CLS_ARP;
        end else begin
            // OAM, SNAP, LLC and other EtherTypes
            cls = AKS_CLS_MAC;
        end
    end
    assign is_ip = (cls != AKS_CLS_MAC) && (cls != AKS_CLS_ARP) &&
                   (cls != AKS_CLS_NONE);

    // Maps a port choice to a key legal for the class;
    // an illegal choice falls back to the MAC key; the NONE class always gets no key
    function automatic aks_key_t pick(input aks_cls_t c,
                                      input logic [2:0] ch);
        aks_key_t k;
        k = aks_key_t'({1'b0, ch});
        case (c)
            AKS_CLS_IP6_MC: begin
                if (!(k inside {AKS_KEY_IP6_VLAN, AKS_KEY_SEVEN}))
                    k = AKS_KEY_MAC;
            end
            AKS_CLS_IP6_UC: begin
                if (k != AKS_KEY_SEVEN)
                    k = AKS_KEY_MAC;
            end
            AKS_CLS_IP4_MC: begin
                if (!(k inside {AKS_KEY_IP4_VLAN, AKS_KEY_SEVEN,
                                AKS_KEY_IP4_L4, AKS_KEY_IP4_GEN}))
                    k = AKS_KEY_MAC;
            end
            AKS_CLS_IP4_UC: begin
                if (!(k inside {AKS_KEY_SEVEN, AKS_KEY_IP4_L4,
                                AKS_KEY_IP4_GEN}))
                    k = AKS_KEY_MAC;
            end
            AKS_CLS_ARP: begin
                if (k != AKS_KEY_ARP)
                    k = AKS_KEY_MAC;
            end
            AKS_CLS_NONE: k = AKS_KEY_NONE;
            default:      k = AKS_KEY_MAC;
        endcase
        return k;
    endfunction

    // Raw key start position
    logic [8:0] rpos;
    logic       rpos_ok;
    always_comb begin
        rpos    = 9'h000;
        rpos_ok = 1'b1;
        case (frame_i.raw_key_position)
            2'd0: begin
                // First DMAC byte; absent without a link layer
                rpos    = 9'h000;
                rpos_ok = ~frame_i.control_word_frame;
            end
            2'd1: rpos = {1'b0, frame_i.l3_pos};
            2'd2: rpos = {1'b0, frame_i.l3_pos} + `AKS_POS_PLUS20;
            default: rpos = {1'b0, frame_i.l3_pos} + `AKS_POS_PLUS40;
        endcase
    end

    // Byte at an index, zero past the visible window
    function automatic logic [7:0] byte_at(input logic [FB*8-1:0] f,
                                           input int idx);
        logic [7:0] r;
        r = 8'h00;
        if (idx < FB) begin
            r = f[idx*8 +: 8];
        end
        return r;
    endfunction

    // Raw key bytes, consecutive from the chosen position
    logic [`AKS_RAW_WIDE*8-1:0]   raw_w;
    logic [`AKS_RAW_NARROW*8-1:0] raw_n;
    genvar gb;
    generate
        for (gb = 0; gb < `AKS_RAW_WIDE; gb++) begin : g_raw
            assign raw_w[gb*8 +: 8] =
                byte_at(frame_bytes_i, int'(rpos) + gb);
            if (gb < `AKS_RAW_NARROW) begin : g_nar
                assign raw_n[gb*8 +: 8] =
                    byte_at(frame_bytes_i, int'(rpos) + gb);
            end
        end
    endgenerate

    // Shared selected 16-bit field after Type/Len
    logic [15:0] sfield;
    int          sidx;
    assign sidx   = int'(frame_i.tl_pos) + int'(roff_q);
    assign sfield = {byte_at(frame_bytes_i, sidx),
                     byte_at(frame_bytes_i, sidx + 1)};

    // Eight range checkers
    logic [`AKS_RNG_N-1:0] rflag;
    logic                  l4ok;
    assign l4ok = is_ip & frame_i.l4_tcp_udp;
    genvar gr;
    generate
        for (gr = 0; gr < `AKS_RNG_N; gr++) begin : g_rng
            logic [15:0] lo;
            logic [15:0] hi;
            logic [15:0] vidx;
            logic [15:0] dscx;
            assign lo   = rlo_q[gr];
            assign hi   = rhi_q[gr];
            assign vidx = {4'h0, frame_i.vid};
            assign dscx = {10'h000, frame_i.dscp};
            always_comb begin
                // Limits inclusive at both ends
                case (rtype_q[gr])
                    `AKS_RT_DPORT: rflag[gr] = l4ok &&
                        frame_i.dport >= lo && frame_i.dport <= hi;
                    `AKS_RT_SPORT: rflag[gr] = l4ok &&
                        frame_i.sport >= lo && frame_i.sport <= hi;
                    `AKS_RT_EITHER: rflag[gr] = l4ok &&
                        ((frame_i.dport >= lo && frame_i.dport <= hi) ||
                         (frame_i.sport >= lo &&
                          frame_i.sport <= hi));
                    `AKS_RT_VID: rflag[gr] =
                        vidx >= lo && vidx <= hi;
                    `AKS_RT_DSCP: rflag[gr] = is_ip &&
                        dscx >= lo && dscx <= hi;
                    `AKS_RT_FIELD: rflag[gr] =
                        sfield >= lo && sfield <= hi;
                    default: rflag[gr] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Per-lookup key choice
    logic     pok;
    logic     en0;
    logic     en1;
    aks_key_t k0;
    aks_key_t k1;
    assign pok = int'(frame_i.port) < NP;
    assign en0 = pok && lk_en_q[2*frame_i.port];
    assign en1 = pok && lk_en_q[2*frame_i.port + 1];
    always_comb begin
        // Raw key request wins over the port setting
        if (frame_i.raw_key_enable) begin
            k0 = rpos_ok ? AKS_KEY_CUSTOM : AKS_KEY_NONE;
            k1 = k0;
        end else begin
            k0 = pick(cls, ksel0_q[3*frame_i.port +: 3]);
            k1 = pick(cls, ksel1_q[3*frame_i.port +: 3]);
        end
        if (!en0) begin
            k0 = AKS_KEY_NONE;
        end
        if (!en1) begin
            k1 = AKS_KEY_NONE;
        end
    end

    // Result register; range vector only in keys that carry it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_o <= '0;
        end else begin
            res_o.valid   <= frame_i.valid;
            res_o.port    <= frame_i.port;
            res_o.key0    <= k0;
            res_o.key1    <= k1;
            res_o.l2_null <= frame_i.control_word_frame;
            res_o.range_flag_vector0 <=
                (k0 inside {AKS_KEY_IP4_L4, AKS_KEY_SEVEN})
                ? rflag : 8'h00;
            res_o.range_flag_vector1 <=
                (k1 inside {AKS_KEY_IP4_L4, AKS_KEY_SEVEN})
                ? rflag : 8'h00;
        end
    end

    // Raw key data, zero unless a raw key was chosen; held while no frame is valid
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            raw_wide_o   <= '0;
            raw_narrow_o <= '0;
        end else if (frame_i.valid) begin
            if (k0 == AKS_KEY_CUSTOM || k1 == AKS_KEY_CUSTOM) begin
                raw_wide_o   <= raw_w;
                raw_narrow_o <= raw_n;
            end else begin
                raw_wide_o   <= '0;
                raw_narrow_o <= '0;
            end
        end
    end

    // Match results used only for enabled lookups
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hit_used_o <= 2'b00;
        end else if (hit_i.valid && int'(hit_i.port) < NP) begin
            hit_used_o <= hit_i.hit &
                lk_en_q[2*hit_i.port +: 2];
        end else begin
            hit_used_o <= 2'b00;
        end
    end

    // Frame counter for status; wraps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fcnt_q <= 16'h0000;
        end else if (frame_i.valid) begin
            fcnt_q <= fcnt_q + 16'h0001;
        end
    end

endmodule

// [aks_key_select_asserts.sv]
// Port assertions for the key select and range check block
`timescale 1ns/1ps
module aks_key_select_chk
    import aks_pkg::*;
#(
    parameter int NP = 8  // Ports served
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire aks_frame_t frame_i,
    input wire aks_hit_t   hit_i,
    input wire aks_res_t   res_o,
    input wire logic [1:0] hit_used_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Served port, no raw key, link frame
    wire logic v;
    assign v = frame_i.valid && frame_i.port < NP
               && !frame_i.raw_key_enable && !frame_i.control_word_frame;
    property p_lat;
        frame_i.valid |=> res_o.valid && res_o.port == $past(frame_i.port);
    endproperty
    a_lat: assert property (p_lat) else $error("result late");
    property p_mac;
        v && frame_i.type_len == 16'h8902 |=> res_o.key0 inside
            {AKS_KEY_MAC, AKS_KEY_NONE};
    endproperty
    a_mac: assert property (p_mac) else $error("oam key");
    property p_uc4;
        v && frame_i.type_len == 16'h0800 && !frame_i.ip_mcast
            |=> res_o.key0 != AKS_KEY_IP4_VLAN;
    endproperty
    a_uc4: assert property (p_uc4) else $error("ipv4 uc key");
    property p_arp;
        v && frame_i.type_len == 16'h0806 |=> res_o.key0 inside
            {AKS_KEY_ARP, AKS_KEY_MAC, AKS_KEY_NONE};
    endproperty
    a_arp: assert property (p_arp) else $error("arp key");
    property p_cwn;
        frame_i.valid && frame_i.control_word_frame
            && !frame_i.raw_key_enable && !(frame_i.ip_ver inside {4, 6})
            |=> res_o.key0 == AKS_KEY_NONE && res_o.key1 == AKS_KEY_NONE;
    endproperty
    a_cwn: assert property (p_cwn) else $error("cw nibble");
    property p_l2n;
        frame_i.valid |=> res_o.l2_null == $past(frame_i.control_word_frame);
    endproperty
    a_l2n: assert property (p_l2n) else $error("l2 null");
    property p_rng;
        res_o.valid && !(res_o.key0 inside {AKS_KEY_IP4_L4, AKS_KEY_SEVEN})
            |-> res_o.range_flag_vector0 == 8'h00;
    endproperty
    a_rng: assert property (p_rng) else $error("range vector");
    property p_raw;
        frame_i.valid && frame_i.raw_key_enable
            && !frame_i.control_word_frame
            |=> res_o.key0 inside {AKS_KEY_CUSTOM, AKS_KEY_NONE};
    endproperty
    a_raw: assert property (p_raw) else $error("raw key");
    property p_hit;
        hit_i.valid |=> (hit_used_o & ~$past(hit_i.hit)) == 2'b00;
    endproperty
    a_hit: assert property (p_hit) else $error("hit use");
    c_raw: cover property (res_o.key0 == AKS_KEY_CUSTOM);
    c_rng: cover property (res_o.range_flag_vector0 != 8'h00);
    c_hit: cover property (hit_used_o != 2'b00);
endmodule
bind aks_key_select aks_key_select_chk #(.NP(NP)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .frame_i(frame_i), .hit_i(hit_i),
    .res_o(res_o), .hit_used_o(hit_used_o));

// [aks_cls_model.sv]
// Upstream classifier model: descriptors, frame bytes, match results
`timescale 1ns/1ps
module aks_cls_model
    import aks_pkg::*;
#(
    parameter int FB = 128  // Visible frame bytes
) (
    input  wire logic       clk_i,
    output aks_frame_t      frame_o,
    output logic [FB*8-1:0] bytes_o,
    output aks_hit_t        hit_o
);
    // Byte j holds j, so raw key data tells its own position
    initial begin
        frame_o = '0;
        hit_o = '0;
        for (int j = 0; j < FB; j++) begin
            bytes_o[8*j+:8] = j[7:0];
        end
    end
    // Raw key request travels with its position; idle fields scrambled
    task automatic send(input aks_frame_t f);
        @(posedge clk_i);
        frame_o <= f;
        @(posedge clk_i);
        frame_o <= {1'b0, ~f[$bits(aks_frame_t)-2:0]};
    endtask
    // One match result for one cycle
    task automatic hit(input logic [3:0] p, input logic [1:0] h);
        @(posedge clk_i);
        hit_o <= '{1'b1, p, h};
        @(posedge clk_i);
        hit_o <= '{1'b0, ~p, ~h};
    endtask
endmodule

// [tb_acl_key_select_range_check.sv]
// Self-checking bench for the key select and range check block
`timescale 1ns/1ps
module tb_acl_key_select_range_check
    import aks_pkg::*;
;
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic          wb_cyc_i = 1'b0;
    logic          wb_stb_i = 1'b0;
    logic          wb_we_i = 1'b0;
    logic [7:0]    wb_adr_i = 8'h00;
    logic [31:0]   wb_dat_i = 32'h0;
    logic [31:0]   wb_dat_o;
    logic          wb_ack_o;
    aks_frame_t    frame_i;
    logic [1023:0] bytes;
    aks_hit_t      hit_i;
    aks_res_t      res_o;
    logic [455:0]  raw_wide_o;
    logic [191:0]  raw_narrow_o;
    logic [1:0]    hit_used_o;
    int            n_fail = 0;
    int            checked = 0;
    always #2.5 clk_i = ~clk_i;
    aks_key_select #(.NP(8), .FB(128)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .frame_i(frame_i), .frame_bytes_i(bytes),
        .hit_i(hit_i), .res_o(res_o), .raw_wide_o(raw_wide_o),
        .raw_narrow_o(raw_narrow_o), .hit_used_o(hit_used_o));
    aks_cls_model #(.FB(128)) cls_u (
        .clk_i(clk_i), .frame_o(frame_i), .bytes_o(bytes), .hit_o(hit_i));
    // Count and report one comparison
    task automatic check(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then drop for one cycle
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        check(n < 20, "no ack");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q === e, "read");
    endtask
    // Key choice of lookup 0 on port 1
    task automatic ksel(input aks_key_t k);
        wr(8'h04, {26'h0, k[2:0], 3'h0});
    endtask
    function automatic aks_frame_t mk(input logic [15:0] tl,
        input logic [3:0] v, input logic mc, input logic cw);
        aks_frame_t f;
        f = '0;
        f.valid = 1'b1;
        f.port = 4'h1;
        f.control_word_frame = cw;
        f.type_len = tl;
        f.ip_ver = v;
        f.ip_mcast = mc;
        f.l3_pos = 8'h0e;
        f.tl_pos = 8'h0c;
        return f;
    endfunction
    // Result shows one cycle after the frame is taken
    task automatic frm(input aks_frame_t f, input aks_key_t k0,
                       input aks_key_t k1);
        cls_u.send(f);
        #1;
        check(res_o.valid === 1'b1 && res_o.key0 === k0
              && res_o.key1 === k1, "keys");
    endtask
    task automatic complete_run;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        aks_frame_t  f;
        logic [7:0]  b;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h00, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rd(8'h3c, 32'h0);
        $display("test reset done");
        wr(8'h00, 32'h4);
        ksel(AKS_KEY_SEVEN);
        rd(8'h04, 32'h20);
        frm(mk(16'h0800, 4'h4, 0, 0), AKS_KEY_SEVEN, AKS_KEY_NONE);
        ksel(AKS_KEY_IP4_VLAN);
        frm(mk(16'h0800, 4'h4, 0, 0), AKS_KEY_MAC, AKS_KEY_NONE);
        frm(mk(16'h0800, 4'h4, 1, 0), AKS_KEY_IP4_VLAN, AKS_KEY_NONE);
        ksel(AKS_KEY_IP6_VLAN);
        frm(mk(16'h86dd, 4'h6, 1, 0), AKS_KEY_IP6_VLAN, AKS_KEY_NONE);
        frm(mk(16'h86dd, 4'h6, 0, 0), AKS_KEY_MAC, AKS_KEY_NONE);
        ksel(AKS_KEY_ARP);
        frm(mk(16'h8035, 4'h0, 0, 0), AKS_KEY_ARP, AKS_KEY_NONE);
        frm(mk(16'h8902, 4'h0, 0, 0), AKS_KEY_MAC, AKS_KEY_NONE);
        ksel(AKS_KEY_IP4_GEN);
        frm(mk(16'h0000, 4'h4, 0, 1), AKS_KEY_IP4_GEN, AKS_KEY_NONE);
        check(res_o.l2_null === 1'b1, "l2 null");
        frm(mk(16'h0000, 4'h6, 0, 1), AKS_KEY_MAC, AKS_KEY_NONE);
        frm(mk(16'h0000, 4'h7, 0, 1), AKS_KEY_NONE, AKS_KEY_NONE);
        // Raw keys at each position; first byte tells the position
        for (int p = 0; p < 4; p++) begin
            f = mk(16'h0800, 4'h4, 0, 0);
            f.raw_key_enable = 1'b1;
            f.raw_key_position = p[1:0];
            b = (p == 0) ? 8'h00 : 8'(14 + 20 * (p - 1));
            frm(f, AKS_KEY_CUSTOM, AKS_KEY_NONE);
            check(raw_wide_o[7:0] === b && raw_wide_o[455:448] === b + 8'd56
                  && raw_narrow_o[191:184] === b + 8'd23, "raw");
        end
        f.control_word_frame = 1'b1;
        f.raw_key_position = 2'h0;
        frm(f, AKS_KEY_NONE, AKS_KEY_NONE);
        $display("test key choice done");
        ksel(AKS_KEY_SEVEN);
        for (int i = 0; i < 8; i++) begin
            wr(8'h40 + 8'(4 * i), 32'(i));
            wr(8'h60 + 8'(4 * i), {16'd200, 16'd40});
        end
        wr(8'h74, 32'h0e0f_0e0f);
        wr(8'h0c, 32'h2);
        f = mk(16'h0800, 4'h4, 0, 0);
        f.l4_tcp_udp = 1'b1;
        f.dport = 16'd200;
        f.sport = 16'd39;
        f.vid = 12'd201;
        f.dscp = 6'd40;
        frm(f, AKS_KEY_SEVEN, AKS_KEY_NONE);
        check(res_o.range_flag_vector0 === 8'h35, "rng tcp");
        f.l4_tcp_udp = 1'b0;
        f.vid = 12'd150;
        frm(f, AKS_KEY_SEVEN, AKS_KEY_NONE);
        check(res_o.range_flag_vector0 === 8'h38, "rng other");
        wr(8'h0c, 32'h3);
        frm(f, AKS_KEY_SEVEN, AKS_KEY_NONE);
        check(res_o.range_flag_vector0 === 8'h18, "rng off");
        cls_u.hit(4'h1, 2'b11);
        #1;
        check(hit_used_o === 2'b01, "hit");
        rd(8'h10, 32'h8800_0012);
        $display("test ranges done");
        complete_run();
    end
    // Tests need under 200 cycles; the watchdog fires after 4000
    initial begin
        #20000;
        n_fail++;
        $display("MISMATCH %0t watchdog", $time);
        complete_run();
    end
endmodule
